// >>> scl_port.sv
// serial configuration port: eeprom autoload master or smbus slave
// assumes straps and gpio are stable around reset release, pins synchronous
`timescale 1ns/1ps
module scl_port
	import scl_pkg::*;
#(
	parameter logic [15:0] SIGNATURE = 16'h5a3c, // arbitrary value
	parameter int QTR = QTR_CYC,
	parameter int FIFO_D = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic mode_strap_high,
	input wire logic mode_strap_low,
	input wire logic transparent_mode,
	input wire logic arbiter_en,
	input wire logic mgmt_clock_pin_i,
	output logic mgmt_clock_pin_o,
	output logic mgmt_clock_pin_oe,
	input wire logic mgmt_data_pin_i,
	output logic mgmt_data_pin_o,
	output logic mgmt_data_pin_oe,
	input wire logic [3:0] gpio_i,
	output logic [3:0] gpio_o,
	output logic [3:0] gpio_oe,
	output logic [3:0] bus_req_hi,
	output logic cfg_wr_valid,
	input wire logic cfg_wr_ready,
	output logic [11:0] cfg_wr_addr,
	output logic [7:0] cfg_wr_data,
	output logic load_done,
	output logic isa_wp,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	initial begin
		if (QTR < 2 || QTR > 1023 || FIFO_D < 2)
			$error("scl_port parameter out of range");
	end

	typedef enum logic [2:0] {E_IDLE, E_START, E_BIT, E_STOP, E_DONE} scl_ee_t;
	typedef enum logic [1:0] {S_DEVW, S_ADDR, S_DEVR, S_READ} scl_step_t;

	logic rs1_r, rst_s_n;
	logic cap_r;
	scl_mode_t mode_r;
	logic [7:0] smb_addr_r;
	scl_ee_t ee_r;
	scl_step_t step_r;
	logic [9:0] qc_r;
	logic [1:0] ph_r;
	logic [3:0] bit_r;
	logic [8:0] sh_r;
	logic [7:0] rxb_r, idx_r, stop_r, sig_hi_r;
	logic scl_r, sda_r, rd_r, sig_ok_r, push_r;
	logic tick, byte_end, last, data_byte;
	logic [7:0] rgn_stop;
	logic rgn_ok;
	logic f_ready, f_valid;
	logic [19:0] f_dout;
	logic [1:0] ctrl_r;
	logic sq_scl_r, sq_sda_r, sb_busy_r, sb_first_r, sb_act_r, sb_ack_r;
	logic [3:0] sb_cnt_r;
	logic [7:0] sb_sh_r, sb_rx_r;
	logic s_start, s_stop, s_rise, s_fall;
	logic [7:0] rd_addr;

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rs1_r <= 1'b0;
			rst_s_n <= 1'b0;
		end else begin
			rs1_r <= 1'b1;
			rst_s_n <= rs1_r;
		end
	end

	// straps are caught once, one clock after release
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			cap_r <= 1'b0;
			mode_r <= MODE_NONE;
			smb_addr_r <= 8'h00;
		end else if (clk_en && !cap_r) begin
			cap_r <= 1'b1;
			if (!mode_strap_high && !mode_strap_low)
				mode_r <= MODE_EEPROM;
			else if (!mode_strap_high && mode_strap_low)
				mode_r <= MODE_SMB;
			smb_addr_r <= {SMB_ADDR_HI, gpio_i, 1'b0};
		end
	end

	// ---- eeprom master ----
	assign tick = (qc_r == 10'(QTR - 1)) && !push_r;
	assign byte_end = tick && ph_r == 2'd3 && bit_r == ACK_SLOT;
	assign data_byte = idx_r >= EE_DATA_BYTE && sig_ok_r;

	always_comb begin
		rgn_ok = 1'b1;
		unique case (rxb_r[4:1])
			RGN_G1: rgn_stop = STOP_G1;
			RGN_G2: rgn_stop = STOP_G2;
			RGN_G3: rgn_stop = STOP_G3;
			RGN_G4: rgn_stop = STOP_G4;
			default: begin
				rgn_stop = STOP_G1;
				rgn_ok = 1'b0;
			end
		endcase
	end

	// nack the byte that ends the load
	always_comb begin
		if (idx_r == EE_SIG_BYTE)
			last = {sig_hi_r, rxb_r} != SIGNATURE;
		else if (idx_r == EE_RGN_BYTE)
			last = !rgn_ok;
		else
			last = idx_r > EE_RGN_BYTE && idx_r == stop_r;
	end

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n)
			qc_r <= '0;
		else if (clk_en && ee_r != E_IDLE && ee_r != E_DONE && !push_r)
			qc_r <= tick ? 10'h000 : qc_r + 1'b1;
	end

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			ee_r <= E_IDLE;
			step_r <= S_DEVW;
			ph_r <= 2'd0;
			bit_r <= 4'h0;
			sh_r <= 9'h1ff;
			rxb_r <= 8'h00;
			scl_r <= 1'b1;
			sda_r <= 1'b1;
			rd_r <= 1'b0;
		end else if (clk_en) begin
			if (ee_r == E_IDLE && mode_r == MODE_EEPROM) begin
				ee_r <= E_START;
			end else if (tick) begin
				ph_r <= ph_r + 1'b1;
				unique case (ee_r)
					E_START: begin
						case (ph_r)
							2'd0: sda_r <= 1'b1;
							2'd1: scl_r <= 1'b1;
							2'd2: sda_r <= 1'b0;
							default: begin
								scl_r <= 1'b0;
								ee_r <= E_BIT;
								bit_r <= 4'h0;
								sh_r <= {EE_DEV, step_r == S_DEVR, 1'b1};
							end
						endcase
					end
					E_BIT: begin
						case (ph_r)
							2'd0: begin
								scl_r <= 1'b0;
								sda_r <= (rd_r && bit_r == ACK_SLOT) ? last
									: sh_r[8];
							end
							2'd1: scl_r <= 1'b1;
							2'd2: if (bit_r < ACK_SLOT)
								rxb_r <= {rxb_r[6:0], mgmt_data_pin_i};
							default: begin
								scl_r <= 1'b0;
								sh_r <= {sh_r[7:0], 1'b1};
								bit_r <= bit_r + 1'b1;
								if (bit_r == ACK_SLOT) begin
									bit_r <= 4'h0;
									sh_r <= 9'h1ff;
									if (!rd_r && rxb_r[0])
										ee_r <= E_STOP;
									else if (step_r == S_DEVW) begin
										step_r <= S_ADDR;
										sh_r <= 9'h001;
									end else if (step_r == S_ADDR) begin
										step_r <= S_DEVR;
										ee_r <= E_START;
									end else if (step_r == S_DEVR) begin
										step_r <= S_READ;
										rd_r <= 1'b1;
									end else if (last)
										ee_r <= E_STOP;
								end
							end
						endcase
					end
					E_STOP: begin
						case (ph_r)
							2'd0: begin
								scl_r <= 1'b0;
								sda_r <= 1'b0;
							end
							2'd1: scl_r <= 1'b1;
							2'd2: sda_r <= 1'b1;
							default: ee_r <= E_DONE;
						endcase
					end
					default: ;
				endcase
				// ack slot of a write byte: rxb_r[0] holds the ack level
				if (ee_r == E_BIT && ph_r == 2'd2 && bit_r == ACK_SLOT && !rd_r)
					rxb_r <= {7'h00, mgmt_data_pin_i};
			end
		end
	end

	// byte bookkeeping, ascending from address zero
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			idx_r <= 8'h00;
			sig_hi_r <= 8'h00;
			sig_ok_r <= 1'b0;
			stop_r <= STOP_G1;
			isa_wp <= 1'b0;
		end else if (clk_en && byte_end && rd_r) begin
			idx_r <= idx_r + 1'b1;
			if (idx_r == 8'h00)
				sig_hi_r <= rxb_r;
			if (idx_r == EE_SIG_BYTE && !last)
				sig_ok_r <= 1'b1;
			if (idx_r == EE_RGN_BYTE)
				stop_r <= rgn_stop;
			if (idx_r == EE_MISC_BYTE)
				isa_wp <= transparent_mode && rxb_r[0];
		end
	end

	// one pending push; the bit engine waits while the fifo is full
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n)
			push_r <= 1'b0;
		else if (clk_en) begin
			if (byte_end && rd_r && data_byte)
				push_r <= 1'b1;
			else if (f_ready)
				push_r <= 1'b0;
		end
	end

	logic [7:0] push_idx_r, push_dat_r;
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			push_idx_r <= 8'h00;
			push_dat_r <= 8'h00;
		end else if (clk_en && byte_end && rd_r) begin
			push_idx_r <= idx_r;
			push_dat_r <= rxb_r;
		end
	end

	scl_fifo #(.W(20), .D(FIFO_D)) u_fifo (
		.clk(clk),
		.rst_n(rst_s_n),
		.clk_en(clk_en),
		.in_valid(push_r),
		.in_ready(f_ready),
		.in_data({cfg_map(push_idx_r), push_dat_r}),
		.out_valid(f_valid),
		.out_ready(!cfg_wr_valid || cfg_wr_ready),
		.out_data(f_dout)
	);

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			cfg_wr_valid <= 1'b0;
			cfg_wr_addr <= 12'h000;
			cfg_wr_data <= 8'h00;
		end else if (clk_en && (!cfg_wr_valid || cfg_wr_ready)) begin
			cfg_wr_valid <= f_valid;
			cfg_wr_addr <= f_dout[19:8];
			cfg_wr_data <= f_dout[7:0];
		end
	end

	// done only once every loaded byte has left the port
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n)
			load_done <= 1'b0;
		else if (clk_en && cap_r && !push_r && !f_valid && !cfg_wr_valid
			&& (ee_r == E_DONE || mode_r != MODE_EEPROM))
			load_done <= 1'b1;
	end

	// ---- smbus slave, write-only: the last received byte is kept for software ----
	assign s_start = sq_scl_r && mgmt_clock_pin_i && sq_sda_r
		&& !mgmt_data_pin_i;
	assign s_stop = sq_scl_r && mgmt_clock_pin_i && !sq_sda_r
		&& mgmt_data_pin_i;
	assign s_rise = !sq_scl_r && mgmt_clock_pin_i;
	assign s_fall = sq_scl_r && !mgmt_clock_pin_i;

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			sq_scl_r <= 1'b1;
			sq_sda_r <= 1'b1;
			sb_busy_r <= 1'b0;
			sb_first_r <= 1'b0;
			sb_act_r <= 1'b0;
			sb_ack_r <= 1'b0;
			sb_cnt_r <= 4'h0;
			sb_sh_r <= 8'h00;
			sb_rx_r <= 8'h00;
		end else if (clk_en) begin
			sq_scl_r <= mgmt_clock_pin_i;
			sq_sda_r <= mgmt_data_pin_i;
			if (mode_r != MODE_SMB || s_stop) begin
				sb_busy_r <= 1'b0;
				sb_act_r <= 1'b0;
				sb_ack_r <= 1'b0;
			end else if (s_start) begin
				sb_busy_r <= 1'b1;
				sb_first_r <= 1'b1;
				sb_act_r <= 1'b0;
				sb_ack_r <= 1'b0;
				sb_cnt_r <= 4'h0;
			end else if (sb_busy_r && s_rise && sb_cnt_r < ACK_SLOT) begin
				sb_sh_r <= {sb_sh_r[6:0], mgmt_data_pin_i};
				sb_cnt_r <= sb_cnt_r + 1'b1;
			end else if (sb_busy_r && s_fall && sb_cnt_r == ACK_SLOT) begin
				sb_cnt_r <= ACK_DONE;
				if (sb_first_r) begin
					sb_act_r <= sb_sh_r == smb_addr_r;
					sb_ack_r <= sb_sh_r == smb_addr_r;
				end else if (sb_act_r) begin
					sb_rx_r <= sb_sh_r;
					sb_ack_r <= 1'b1;
				end
			end else if (sb_busy_r && s_fall && sb_cnt_r == ACK_DONE) begin
				sb_ack_r <= 1'b0;
				sb_cnt_r <= 4'h0;
				sb_first_r <= 1'b0;
				sb_busy_r <= sb_act_r;
			end
		end
	end

	// ---- shared pins and gpio ----
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			mgmt_clock_pin_o <= 1'b1;
			mgmt_clock_pin_oe <= 1'b0;
			mgmt_data_pin_o <= 1'b1;
			mgmt_data_pin_oe <= 1'b0;
		end else if (clk_en) begin
			// one pin pair, protocol picked by the captured mode
			mgmt_clock_pin_o <= scl_r;
			mgmt_clock_pin_oe <= mode_r == MODE_EEPROM;
			if (mode_r == MODE_SMB) begin
				mgmt_data_pin_o <= 1'b0;
				mgmt_data_pin_oe <= sb_ack_r;
			end else begin
				mgmt_data_pin_o <= sda_r;
				mgmt_data_pin_oe <= mode_r == MODE_EEPROM && !(ee_r == E_BIT
					&& (rd_r ? bit_r < ACK_SLOT : bit_r == ACK_SLOT));
			end
		end
	end

	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			gpio_o <= 4'h0;
			gpio_oe <= 4'h0;
			bus_req_hi <= 4'hf;
		end else if (clk_en) begin
			// address straps were caught at reset, so later use is free
			gpio_o <= {ctrl_r, 2'b00};
			gpio_oe <= arbiter_en ? 4'h0 : 4'hc;
			bus_req_hi <= arbiter_en ? gpio_i : 4'hf;
		end
	end

	// ---- axi4-lite slave ----
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
			ctrl_r <= 2'b00;
		end else if (clk_en) begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
				&& !s_axi_awready;
			s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
				&& !s_axi_awready;
			if (s_axi_awready) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= s_axi_awaddr == REG_CTRL ? AXI_OKAY : AXI_SLVERR;
				if (s_axi_awaddr == REG_CTRL && s_axi_wstrb[0])
					ctrl_r <= s_axi_wdata[1:0];
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	assign rd_addr = s_axi_araddr;
	always_ff @(posedge clk or negedge rst_s_n) begin
		if (!rst_s_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= AXI_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= AXI_OKAY;
				unique case (rd_addr)
					REG_CTRL: s_axi_rdata <= {30'h0, ctrl_r};
					REG_STATUS: s_axi_rdata <= {16'h0, stop_r, 2'b00,
						isa_wp, sig_ok_r, load_done, 1'b0, mode_r};
					REG_SMB: s_axi_rdata <= {16'h0, sb_rx_r, smb_addr_r};
					REG_GPIO: s_axi_rdata <= {28'h0, gpio_i};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= AXI_SLVERR;
					end
				endcase
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ---- checks ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_s_n);

	sequence s_loaded;
		cap_r && mode_r == MODE_EEPROM;
	endsequence
	sequence s_failed;
		ee_r == E_DONE && !sig_ok_r;
	endsequence

	property p_mode_ee;
		$rose(cap_r) && !$past(mode_strap_high) && !$past(mode_strap_low)
			|-> mode_r == MODE_EEPROM;
	endproperty
	a_mode_ee: assert property (p_mode_ee) else $error("eeprom mode lost");
	property p_mode_smb;
		$rose(cap_r) && mode_r == MODE_SMB |-> !$past(mode_strap_high)
			&& $past(mode_strap_low);
	endproperty
	a_mode_smb: assert property (p_mode_smb) else $error("bad smb mode");
	property p_ee_clk;
		s_loaded ##1 clk_en |-> mgmt_clock_pin_oe;
	endproperty
	a_ee_clk: assert property (p_ee_clk) else $error("clock not driven");
	property p_smb_pins;
		mode_r == MODE_SMB ##1 clk_en |-> !mgmt_clock_pin_oe
			&& (!mgmt_data_pin_oe || !mgmt_data_pin_o);
	endproperty
	a_smb_pins: assert property (p_smb_pins) else $error("smb drive high");
	property p_smb_addr;
		cap_r |-> smb_addr_r[7:5] == SMB_ADDR_HI && !smb_addr_r[0];
	endproperty
	a_smb_addr: assert property (p_smb_addr) else $error("smb address");
	property p_sig_gate;
		push_r |-> sig_ok_r && push_idx_r >= EE_DATA_BYTE;
	endproperty
	a_sig_gate: assert property (p_sig_gate) else $error("unsigned push");
	property p_region;
		push_r |-> push_idx_r <= stop_r;
	endproperty
	a_region: assert property (p_region) else $error("past region end");
	property p_no_write;
		s_failed |-> (!push_r && !cfg_wr_valid) [*3];
	endproperty
	a_no_write: assert property (p_no_write) else $error("write on fail");
	property p_isa;
		isa_wp |-> $past(transparent_mode) || $stable(isa_wp);
	endproperty
	a_isa: assert property (p_isa) else $error("isa protect");
	property p_gpio;
		!arbiter_en ##1 clk_en |-> gpio_oe == 4'hc;
	endproperty
	a_gpio: assert property (p_gpio) else $error("gpio dirs");
	property p_done;
		$rose(load_done) |-> !f_valid && !push_r && !cfg_wr_valid;
	endproperty
	a_done: assert property (p_done) else $error("done too early");
endmodule

// >>> scl_pkg.sv
// constants, types and the eeprom-to-config map of the serial config port
// assumes a 250 MHz core clock and an i2c memory at a fixed device address
package scl_pkg;

	typedef enum logic [1:0] {MODE_NONE, MODE_EEPROM, MODE_SMB} scl_mode_t;

	localparam int CLK_MHZ = 250;
	localparam int I2C_QTR_NS = 2500;
	localparam int QTR_CYC = (I2C_QTR_NS * CLK_MHZ + 999) / 1000;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SMB = 8'h08;
	localparam logic [7:0] REG_GPIO = 8'h0c;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	localparam logic [6:0] EE_DEV = 7'h50;
	localparam logic [7:0] EE_SIG_BYTE = 8'h01;
	localparam logic [7:0] EE_RGN_BYTE = 8'h02;
	localparam logic [7:0] EE_MISC_BYTE = 8'h03;
	localparam logic [7:0] EE_DATA_BYTE = 8'h04;
	localparam logic [3:0] RGN_G1 = 4'h0;
	localparam logic [3:0] RGN_G2 = 4'h1;
	localparam logic [3:0] RGN_G3 = 4'h3;
	localparam logic [3:0] RGN_G4 = 4'h7;
	localparam logic [7:0] STOP_G1 = 8'h0b;
	localparam logic [7:0] STOP_G2 = 8'h67;
	localparam logic [7:0] STOP_G3 = 8'haf;
	localparam logic [7:0] STOP_G4 = 8'hd7;
	localparam logic [2:0] SMB_ADDR_HI = 3'h6;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] ACK_DONE = 4'h9;

	// bytes past the last listed range keep their own offset
	function automatic logic [11:0] cfg_map(input logic [7:0] b);
		logic [7:0] s;
		logic [11:0] base;
		s = b;
		base = {4'h0, b};
		if (b inside {[8'h04:8'h07]}) begin s = 8'h04; base = 12'h000; end
		else if (b == 8'h0c) begin s = 8'h0c; base = 12'h034; end
		else if (b inside {[8'h0d:8'h0e]}) begin s = 8'h0d; base = 12'h040; end
		else if (b inside {[8'h0f:8'h10]}) begin s = 8'h0f; base = 12'h042; end
		else if (b inside {[8'h11:8'h14]}) begin s = 8'h11; base = 12'h048; end
		else if (b inside {[8'h15:8'h18]}) begin s = 8'h15; base = 12'h068; end
		else if (b inside {[8'h19:8'h1a]}) begin s = 8'h19; base = 12'h081; end
		else if (b == 8'h1b) begin s = 8'h1b; base = 12'h108; end
		else if (b inside {[8'h1c:8'h1e]}) begin s = 8'h1c; base = 12'h091; end
		else if (b inside {[8'h1f:8'h21]}) begin s = 8'h1f; base = 12'h0a1; end
		else if (b inside {[8'h22:8'h2d]}) begin s = 8'h22; base = 12'h0a4; end
		else if (b inside {[8'h2e:8'h30]}) begin s = 8'h2e; base = 12'h0b1; end
		else if (b inside {[8'h31:8'h34]}) begin s = 8'h31; base = 12'h0b4; end
		else if (b inside {[8'h35:8'h38]}) begin s = 8'h35; base = 12'h0bc; end
		else if (b inside {[8'h39:8'h3c]}) begin s = 8'h39; base = 12'h0c4; end
		else if (b inside {[8'h3d:8'h48]}) begin s = 8'h3d; base = 12'h0cc; end
		else if (b inside {[8'h49:8'h4a]}) begin s = 8'h49; base = 12'h0d9; end
		else if (b inside {[8'h4b:8'h4c]}) begin s = 8'h4b; base = 12'h0f1; end
		return base + {4'h0, b - s};
	endfunction

endpackage

// >>> scl_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes one clock, an asynchronous active-low reset and a clock enable
`timescale 1ns/1ps
module scl_fifo #(
	parameter int W = 20,
	parameter int D = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	initial begin
		if (D < 2 || (1 << AW) != D)
			$error("scl_fifo depth must be a power of two");
	end

	logic [W-1:0] mem_r [D];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;

	assign in_ready = (wp_r - rp_r) != (AW+1)'(D);
	assign out_valid = wp_r != rp_r;
	assign out_data = mem_r[rp_r[AW-1:0]];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
		end else if (clk_en && in_valid && in_ready) begin
			mem_r[wp_r[AW-1:0]] <= in_data;
			wp_r <= wp_r + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rp_r <= '0;
		else if (clk_en && out_valid && out_ready)
			rp_r <= rp_r + 1'b1;
	end
endmodule

// >>> scl_ee_model.sv
// behavioural i2c memory answering at device address 50h
// assumes resolved scl and sda wires, sda pulled up when nobody pulls low
`timescale 1ns/1ps
module scl_ee_model (
	input wire logic scl,
	input wire logic sda,
	output logic sda_low
);
	logic [7:0] mem [256];
	logic [7:0] ptr = 0, sh = 0;
	logic rd = 0, rd_nxt = 0, hdr = 0, sel = 0;
	int bitn = 0;
	initial sda_low = 0;
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			bitn = 0;
			hdr = 1;
			rd = 0;
			sda_low = 0;
		end
	end
	always @(posedge scl) begin
		if (bitn < 8 && !rd)
			sh = {sh[6:0], sda};
		// a master nack ends the sequential read
		if (bitn == 8 && rd && sda)
			rd_nxt = 0;
		bitn++;
	end
	// data changes only while scl is low, released bits float to the pull-up
	always @(negedge scl) begin
		if (bitn == 8 && !rd) begin
			if (hdr) begin
				sel = sh[7:1] == 7'h50;
				rd_nxt = sh[0];
			end else if (sel) begin
				ptr = sh;
			end
			hdr = 0;
			sda_low = sel;
		end else if (bitn == 8) begin
			sda_low = 0;
		end else if (bitn == 9) begin
			bitn = 0;
			rd = rd_nxt & sel;
			sh = mem[ptr];
			if (rd)
				ptr++;
			sda_low = rd & !sh[7];
		end else if (rd) begin
			sda_low = !sh[7-bitn];
		end
	end
endmodule

// >>> serial_config_autoload_port_test.sv
// autoload table rows, register access, then the smbus slave mode
// assumes scl_ee_model on the shared pins and a pull-up on the data wire
`timescale 1ns/1ps
module serial_config_autoload_port_test;
	import scl_pkg::*;
	typedef struct packed {
		logic [15:0] sig;
		logic [7:0] rgn;
		logic [7:0] misc;
		logic tm;
		logic [8:0] n;
		logic wp;
	} scl_row_t;
	localparam logic [15:0] SIG = 16'h2b7e; // arbitrary value
	localparam scl_row_t ROWS [6] = '{
		'{SIG, 8'h00, 8'h01, 1'b1, 9'h008, 1'b1},
		'{SIG, 8'h02, 8'h00, 1'b0, 9'h064, 1'b0},
		'{SIG, 8'h06, 8'h01, 1'b0, 9'h0ac, 1'b0},
		'{SIG, 8'h0e, 8'h00, 1'b1, 9'h0d4, 1'b0},
		'{16'h2b7f, 8'h00, 8'h01, 1'b1, 9'h000, 1'b0},
		'{SIG, 8'h04, 8'h00, 1'b0, 9'h000, 1'b0}};
	logic clk, rst_n = 0, mode_strap_high = 0, mode_strap_low = 0;
	logic transparent_mode = 0, arbiter_en = 0, host_scl = 1, host_low = 0;
	logic scl_o, scl_oe, sda_o, sda_oe, ee_low, load_done, isa_wp;
	logic cfg_wr_valid, cfg_wr_ready = 1, ack, clk_en = 1;
	logic [3:0] gpio_i = 0, gpio_o, gpio_oe, bus_req_hi;
	logic [11:0] cfg_wr_addr;
	logic [7:0] cfg_wr_data, awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d, ea;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rs;
	int cyc = 0, nwr = 0, errors = 0, n_compared = 0;
	wire scl = scl_oe ? scl_o : host_scl;
	wire sda = ((sda_oe && !sda_o) || ee_low || host_low) ? 1'b0 : 1'b1;
	scl_port #(.SIGNATURE(SIG), .QTR(4), .FIFO_D(8)) u_dut (
		.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
		.mode_strap_high(mode_strap_high), .mode_strap_low(mode_strap_low),
		.transparent_mode(transparent_mode), .arbiter_en(arbiter_en),
		.mgmt_clock_pin_i(scl), .mgmt_clock_pin_o(scl_o),
		.mgmt_clock_pin_oe(scl_oe), .mgmt_data_pin_i(sda),
		.mgmt_data_pin_o(sda_o), .mgmt_data_pin_oe(sda_oe),
		.gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
		.bus_req_hi(bus_req_hi), .cfg_wr_valid(cfg_wr_valid),
		.cfg_wr_ready(cfg_wr_ready), .cfg_wr_addr(cfg_wr_addr),
		.cfg_wr_data(cfg_wr_data), .load_done(load_done), .isa_wp(isa_wp),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	scl_ee_model u_ee (.scl(scl), .sda(sda), .sda_low(ee_low));
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic do_reset;
		rst_n <= 0;
		repeat (2) @(posedge clk);
		chk(bus_req_hi, 4'hf);
		rst_n <= 1;
		repeat (4) @(posedge clk);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clk);
			if (awready === 1'b1)
				awvalid <= 0;
			if (wready === 1'b1)
				wvalid <= 0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 0;
		@(posedge clk);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk);
			if (arready === 1'b1)
				arvalid <= 0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rs = rresp;
		rready <= 0;
		@(posedge clk);
	endtask
	// the host only moves data while its clock is low
	task automatic smb_bit(input logic b, output logic s);
		host_low <= !b;
		repeat (8) @(posedge clk);
		host_scl <= 1;
		repeat (8) @(posedge clk);
		s = sda;
		host_scl <= 0;
		repeat (8) @(posedge clk);
	endtask
	task automatic smb_byte(input logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			smb_bit(b[i], s);
		smb_bit(1'b1, ack);
	endtask
	task automatic smb_frame(input logic [7:0] a, input logic [7:0] b);
		host_low <= 1;
		repeat (8) @(posedge clk);
		host_scl <= 0;
		smb_byte(a);
		if (ack === 1'b0)
			smb_byte(b);
		host_low <= 1;
		repeat (8) @(posedge clk);
		host_scl <= 1;
		repeat (8) @(posedge clk);
		host_low <= 0;
		repeat (8) @(posedge clk);
	endtask
	// a long stall early in each load; in rows 1 to 3 it fills the fifo until it refuses
	always @(posedge clk) begin
		cyc <= rst_n ? cyc + 1 : 0;
		cfg_wr_ready <= !(cyc inside {[400:3400]});
		if (cfg_wr_valid === 1'b1 && cfg_wr_ready === 1'b1) begin
			chk(cfg_wr_data, u_ee.mem[nwr + 4]);
			ea = (nwr < 4) ? nwr : (nwr == 8) ? 32'h34 : nwr + 4;
			if (nwr < 9)
				chk(cfg_wr_addr, ea);
			nwr++;
		end
	end
	initial begin
		#390000;
		errors++;
		$display("Error at %0t: watchdog %h expected %h", $time, 0, 1);
		conclude;
	end
	initial begin
		for (int r = 0; r < 6; r++) begin
			for (int i = 4; i < 256; i++)
				u_ee.mem[i] = 8'(i) ^ 8'h5a;
			{u_ee.mem[0], u_ee.mem[1]} = ROWS[r].sig;
			u_ee.mem[2] = ROWS[r].rgn;
			u_ee.mem[3] = ROWS[r].misc;
			transparent_mode <= ROWS[r].tm;
			nwr = 0;
			do_reset;
			while (load_done !== 1'b1 || cyc < 3500)
				@(posedge clk);
			repeat (100) @(posedge clk);
			chk(nwr, ROWS[r].n);
			chk(isa_wp, ROWS[r].wp);
			chk(scl_oe, 1);
			axi_rd(REG_STATUS);
			chk(d[1:0], 1);
			chk(d[4], r != 4);
			$display("autoload row %0d done", r);
		end
		axi_wr(REG_CTRL, 32'h0000_0003);
		chk(rs, AXI_OKAY);
		chk({gpio_o[3:2], gpio_oe}, 6'h3c);
		axi_wr(REG_STATUS, 32'h0000_0000);
		chk(rs, AXI_SLVERR);
		axi_rd(8'h10);
		chk(rs, AXI_SLVERR);
		gpio_i <= 4'h5;
		arbiter_en <= 1;
		repeat (3) @(posedge clk);
		chk(bus_req_hi, 4'h5);
		axi_rd(REG_GPIO);
		chk(d[3:0], 4'h5);
		// a low clock enable must hold the old request copy
		clk_en <= 0;
		gpio_i <= 4'h9;
		repeat (3) @(posedge clk);
		chk(bus_req_hi, 4'h5);
		clk_en <= 1;
		repeat (2) @(posedge clk);
		chk(bus_req_hi, 4'h9);
		$display("register and gpio test done");
		arbiter_en <= 0;
		mode_strap_low <= 1;
		gpio_i <= 4'ha;
		do_reset;
		gpio_i <= 4'h3;
		// done and pin enables are launched on the last reset edge
		@(posedge clk);
		chk(scl_oe, 0);
		chk(load_done, 1);
		axi_rd(REG_SMB);
		chk(d[7:0], {SMB_ADDR_HI, 4'ha, 1'b0});
		smb_frame({SMB_ADDR_HI, 4'h3, 1'b0}, 8'h11);
		chk(ack, 1);
		smb_frame({SMB_ADDR_HI, 4'ha, 1'b0}, 8'hc5);
		chk(ack, 0);
		chk(sda_o, 0);
		axi_rd(REG_SMB);
		chk(d[15:8], 8'hc5);
		axi_rd(REG_STATUS);
		chk(d[1:0], 2);
		$display("smbus test done");
		conclude;
	end
endmodule
